/* core/irq_sleep_pkg.sv */
// constants for the peripheral interrupt and sleep/wake controller
// assumes a byte-wide register port with one-cycle read latency
package irq_sleep_pkg;
	localparam logic [3:0] ADDR_MAIN_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_ENABLE_ONE  = 4'h1;
	localparam logic [3:0] ADDR_ENABLE_TWO  = 4'h2;
	localparam logic [3:0] ADDR_REQUEST_ONE = 4'h3;
	localparam logic [3:0] ADDR_REQUEST_TWO = 4'h4;
	localparam logic [3:0] ADDR_STATUS      = 4'h5;
	localparam logic [3:0] ADDR_OPTION      = 4'h6;
	// main control bit positions
	localparam int GLOBAL_EN_BIT = 7;
	localparam int PERIPH_EN_BIT = 6;
	// implemented bits of the second enable/request pair
	localparam logic [7:0] TWO_IMPL_MASK   = 8'hb8;
	// request one bits that software may write; serial rx/tx are read-only
	localparam logic [7:0] ONE_WRITE_MASK  = 8'hcf;
	// status bits
	localparam int TIMEOUT_BIT   = 4;
	localparam int POWERDOWN_BIT = 3;
	localparam logic [7:0] RESET_ZERO     = 8'h00;
	localparam logic [7:0] STATUS_RESET   = 8'h18;
	localparam logic [7:0] OPTION_RESET   = 8'hff;
	localparam logic [15:0] ISR_VECTOR    = 16'h0004;
	typedef enum logic [2:0] {
		RUN    = 3'b001,
		ASLEEP = 3'b010,
		WAKE   = 3'b100
	} power_state_t;
endpackage

/* core/peripheral_irq_sleep_wake.sv */
// peripheral interrupt flags, enables and sleep entry / wake-up control
// assumes the core pulses sleepExec for one cycle per sleep instruction
// and that peripheral events are already on clk
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: enable two holds bits 7,5,4,3 only
// R2: peripheral sources need periph enable too
// R3: request one holds eight peripheral flags
// R4: serial rx/tx flags are read-only
// R5: request two holds bits 7,5,4,3 only
// R6: flags set regardless of enables
// R7: software clears flags before enabling
// R8: enables and flags reset to zero
// R9: sleep entry clears powerdown, sets timeout
// R10: watchdog cleared on sleep entry
// R11: cpu clock stopped during sleep
// R12: timer1 runs in sleep on external clocks
// R13: converter and sense oscillator keep running; converter runs in sleep only with converterOscSel set
// R14: pins hold state through sleep
// R15: non-watchdog resets unaffected by sleep
// R16: resets restart, interrupts/watchdog resume
// R17: next instruction prefetched during sleep
// R18: enabled source wakes regardless of global
// R19: global set vectors after prefetched instruction
// R20: software puts nop after sleep
// R21: watchdog cleared on every wake
// R22: pending enabled flag makes sleep nop
// R23: service vector is 0004h
// R24: wake request is masked flag or
module peripheral_irq_sleep_wake (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWriteData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regReadData,
	input  wire logic [7:0]  eventsOne,
	input  wire logic [7:0]  eventsTwo,
	input  wire logic        serialRxClear,
	input  wire logic        serialTxClear,
	input  wire logic [2:0]  coreEvents,
	input  wire logic        watchdogTimeout,
	input  wire logic        watchdogRunsInSleep,
	input  wire logic        timer1ExtClockSel,
	input  wire logic        converterOscSel,
	input  wire logic        sleepExec,
	input  wire logic [15:0] sleepPc,
	output logic             cpuClockEnable,
	output logic             watchdogClear,
	output logic             watchdogRun,
	output logic             timer1Run,
	output logic             converterRun,
	output logic             senseOscRun,
	output logic             pinHold,
	output logic             prefetchValid,
	output logic      [15:0] prefetchAddr,
	output logic             vectorTake,
	output logic      [15:0] vectorAddr,
	output logic             wakeResume
);
	// main control: bits 7..3 enables, bits 2..0 core flags
	logic [7:0] mainCtrl;
	logic [7:0] enableOne;
	logic [7:0] enableTwo;
	logic [7:0] requestOne;
	logic [7:0] requestTwo;
	logic [7:0] statusReg;
	logic [7:0] optionReg;
	irq_sleep_pkg::power_state_t state;
	logic wakeRequest;
	logic entering;
	logic sleeping;
	logic wrMain;
	logic wrEnOne;
	logic wrEnTwo;
	logic wrReqOne;
	logic wrReqTwo;
	logic wrOpt;
	logic [7:0] next_readData;

	assign wrMain   = regWrite && regAddr == irq_sleep_pkg::ADDR_MAIN_CTRL;
	assign wrEnOne  = regWrite && regAddr == irq_sleep_pkg::ADDR_ENABLE_ONE;
	assign wrEnTwo  = regWrite && regAddr == irq_sleep_pkg::ADDR_ENABLE_TWO;
	assign wrReqOne = regWrite && regAddr == irq_sleep_pkg::ADDR_REQUEST_ONE;
	assign wrReqTwo = regWrite && regAddr == irq_sleep_pkg::ADDR_REQUEST_TWO;
	assign wrOpt    = regWrite && regAddr == irq_sleep_pkg::ADDR_OPTION;

	// no global enable term here: wake ignores it
	assign wakeRequest = (|(mainCtrl[5:3] & mainCtrl[2:0])) ||
		(mainCtrl[irq_sleep_pkg::PERIPH_EN_BIT] &&
		 (|(enableOne & requestOne) || |(enableTwo & requestTwo))); // R24 R2 R18

	// real sleep entry; a pending enabled flag turns the strobe into a nop
	assign entering = state == irq_sleep_pkg::RUN && sleepExec && !wakeRequest; // R9 R22
	// high from the entry edge until a wake source shows, so the run outputs
	// switch on the same edge as the cpu clock gate instead of a cycle late
	assign sleeping = entering ||
		(state == irq_sleep_pkg::ASLEEP && !(wakeRequest || watchdogTimeout)); // R11

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mainCtrl <= irq_sleep_pkg::RESET_ZERO;
		end else begin
			// event set wins over software clear
			mainCtrl <= (wrMain ? regWriteData : mainCtrl) |
				{5'h00, coreEvents}; // R6
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enableOne <= irq_sleep_pkg::RESET_ZERO; // R8
			enableTwo <= irq_sleep_pkg::RESET_ZERO; // R8
			optionReg <= irq_sleep_pkg::OPTION_RESET;
		end else begin
			if (wrEnOne)
				enableOne <= regWriteData;
			if (wrEnTwo)
				enableTwo <= regWriteData & irq_sleep_pkg::TWO_IMPL_MASK; // R1
			if (wrOpt)
				optionReg <= regWriteData;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			requestOne <= irq_sleep_pkg::RESET_ZERO; // R8
			requestTwo <= irq_sleep_pkg::RESET_ZERO; // R8
		end else begin
			// rx/tx follow their peripheral, never the bus
			requestOne <= (wrReqOne ?
				((regWriteData & irq_sleep_pkg::ONE_WRITE_MASK) |
				 (requestOne & ~irq_sleep_pkg::ONE_WRITE_MASK)) : requestOne) // R4
				& ~{2'b00, serialRxClear, serialTxClear, 4'h0}
				| eventsOne; // R3 R6
			requestTwo <= ((wrReqTwo ? regWriteData : requestTwo) | eventsTwo)
				& irq_sleep_pkg::TWO_IMPL_MASK; // R5 R6
		end
	end

	always_comb begin
		next_readData = 8'h00;
		case (regAddr)
			irq_sleep_pkg::ADDR_MAIN_CTRL:   next_readData = mainCtrl;
			irq_sleep_pkg::ADDR_ENABLE_ONE:  next_readData = enableOne;
			irq_sleep_pkg::ADDR_ENABLE_TWO:  next_readData = enableTwo;
			irq_sleep_pkg::ADDR_REQUEST_ONE: next_readData = requestOne;
			irq_sleep_pkg::ADDR_REQUEST_TWO: next_readData = requestTwo;
			irq_sleep_pkg::ADDR_STATUS:      next_readData = statusReg;
			irq_sleep_pkg::ADDR_OPTION:      next_readData = optionReg;
			default:                         next_readData = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			regReadData <= 8'h00;
		else if (regRead)
			regReadData <= next_readData;
		else
			regReadData <= 8'h00;
	end

	// power state: any device reset returns to run, asleep or not
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= irq_sleep_pkg::RUN; // R15 R16
		end else begin
			case (state)
				irq_sleep_pkg::RUN:
					if (sleepExec && !wakeRequest)
						state <= irq_sleep_pkg::ASLEEP; // R9 R22
				irq_sleep_pkg::ASLEEP:
					if (wakeRequest || watchdogTimeout)
						state <= irq_sleep_pkg::WAKE; // R16 R18
				irq_sleep_pkg::WAKE:
					state <= irq_sleep_pkg::RUN;
				default:
					state <= irq_sleep_pkg::RUN;
			endcase
		end
	end

	// status: powerdown cleared, timeout set on real sleep entry only
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			statusReg <= irq_sleep_pkg::STATUS_RESET;
		else if (state == irq_sleep_pkg::RUN && sleepExec && !wakeRequest) begin
			statusReg[irq_sleep_pkg::POWERDOWN_BIT] <= 1'b0; // R9
			statusReg[irq_sleep_pkg::TIMEOUT_BIT]   <= 1'b1; // R9
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cpuClockEnable <= 1'b1;
			watchdogClear  <= 1'b0;
			watchdogRun    <= 1'b1;
			timer1Run      <= 1'b1;
			converterRun   <= 1'b1;
			senseOscRun    <= 1'b1;
			pinHold        <= 1'b0;
			prefetchValid  <= 1'b0;
			prefetchAddr   <= 16'h0000;
			wakeResume     <= 1'b0;
		end else begin
			// sleep nop leaves the watchdog alone
			watchdogClear <= (state == irq_sleep_pkg::RUN && sleepExec && !wakeRequest) ||
				(state == irq_sleep_pkg::ASLEEP &&
				 (wakeRequest || watchdogTimeout)); // R10 R21 R22
			cpuClockEnable <= !sleeping; // R11
			watchdogRun  <= !sleeping || watchdogRunsInSleep; // R10
			timer1Run    <= !sleeping || timer1ExtClockSel; // R12
			converterRun <= !sleeping || converterOscSel; // R13
			senseOscRun  <= 1'b1; // R13
			// pins frozen, not tri-stated, while asleep
			pinHold <= (state == irq_sleep_pkg::ASLEEP) ||
				(state == irq_sleep_pkg::RUN && sleepExec && !wakeRequest); // R14
			if (state == irq_sleep_pkg::RUN && sleepExec) begin
				prefetchValid <= 1'b1; // R17
				prefetchAddr  <= sleepPc + 16'h0001; // R17
			end else if (state == irq_sleep_pkg::RUN) begin
				prefetchValid <= 1'b0;
			end
			wakeResume <= state == irq_sleep_pkg::WAKE; // R19
		end
	end

	// vector after the prefetched instruction when global enable set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vectorTake <= 1'b0;
			vectorAddr <= 16'h0000;
		end else begin
			vectorTake <= state == irq_sleep_pkg::WAKE &&
				mainCtrl[irq_sleep_pkg::GLOBAL_EN_BIT] && wakeRequest; // R19
			vectorAddr <= irq_sleep_pkg::ISR_VECTOR; // R23
		end
	end

	a_sleep_nop_pending: assert property (@(posedge clk) disable iff (reset) // R22
		state == irq_sleep_pkg::RUN && sleepExec && wakeRequest |=>
			!watchdogClear && state == irq_sleep_pkg::RUN)
		else $error("sleep with pending enabled flag was not a nop");

	sequence s_enter;
		state == irq_sleep_pkg::RUN && sleepExec && !wakeRequest;
	endsequence

	a_entry_status: assert property (@(posedge clk) disable iff (reset) // R9
		s_enter |=> !statusReg[irq_sleep_pkg::POWERDOWN_BIT] &&
			statusReg[irq_sleep_pkg::TIMEOUT_BIT] && watchdogClear)
		else $error("sleep entry did not update status and watchdog");

	a_clock_stopped: assert property (@(posedge clk) disable iff (reset) // R11
		s_enter |=> !cpuClockEnable ##1 (state != irq_sleep_pkg::ASLEEP || !cpuClockEnable
			|| $past(wakeRequest || watchdogTimeout)))
		else $error("cpu clock ran during sleep");

	a_wake_clear: assert property (@(posedge clk) disable iff (reset) // R21
		state == irq_sleep_pkg::ASLEEP && (wakeRequest || watchdogTimeout) |=>
			watchdogClear && state == irq_sleep_pkg::WAKE ##1 wakeResume)
		else $error("wake did not clear watchdog");

	a_vector_addr: assert property (@(posedge clk) disable iff (reset) // R23
		vectorTake |-> vectorAddr == 16'h0004 && $past(state) == irq_sleep_pkg::WAKE)
		else $error("vector taken at wrong address or time");

	a_serial_readonly: assert property (@(posedge clk) disable iff (reset) // R4
		wrReqOne && !eventsOne[5] && !requestOne[5] |=> !requestOne[5])
		else $error("serial rx flag written by software");

	a_two_unused: assert property (@(posedge clk) disable iff (reset) // R1
		(enableTwo & ~8'hb8) == 8'h00 && (requestTwo & ~8'hb8) == 8'h00)
		else $error("unimplemented bit set");

	a_flag_sets: assert property (@(posedge clk) disable iff (reset) // R6
		eventsOne[0] |=> requestOne[0])
		else $error("event lost");

	a_periph_gate: assert property (@(posedge clk) disable iff (reset) // R2
		!mainCtrl[irq_sleep_pkg::PERIPH_EN_BIT] && (mainCtrl[5:3] & mainCtrl[2:0]) == 3'h0
			|-> !wakeRequest)
		else $error("peripheral wake without periph enable");

	a_prefetch_next: assert property (@(posedge clk) disable iff (reset) // R17
		state == irq_sleep_pkg::RUN && sleepExec |=>
			prefetchValid && prefetchAddr == $past(sleepPc) + 16'h0001)
		else $error("wrong prefetch address");

	// a pending enabled flag at the sleep strobe: the sleep is skipped, only the prefetch still happens
	sequence s_nop;
		state == irq_sleep_pkg::RUN && sleepExec && wakeRequest;
	endsequence

	sequence s_wake;
		state == irq_sleep_pkg::ASLEEP && (wakeRequest || watchdogTimeout);
	endsequence

	// one wake cycle, then back in run with the resume pulse and the clock on
	sequence s_resume;
		state == irq_sleep_pkg::WAKE ##1
			state == irq_sleep_pkg::RUN && wakeResume && cpuClockEnable;
	endsequence

	a_nop_status: assert property (@(posedge clk) disable iff (reset) // R22
		s_nop |=> $stable(statusReg) && cpuClockEnable && !pinHold)
		else $error("sleep nop changed status or stopped the clock");

	a_wake_steps: assert property (@(posedge clk) disable iff (reset) // R16
		s_wake |=> s_resume)
		else $error("wake did not pass through resume");

	a_wake_clock: assert property (@(posedge clk) disable iff (reset) // R21
		s_wake |=> watchdogClear && cpuClockEnable)
		else $error("wake did not restart the clock");

	a_asleep_holds: assert property (@(posedge clk) disable iff (reset) // R11
		state == irq_sleep_pkg::ASLEEP && !wakeRequest && !watchdogTimeout |=>
			state == irq_sleep_pkg::ASLEEP && !cpuClockEnable)
		else $error("left sleep without a wake source");

	// selects are levels; compare against what the flops saw at their edge
	a_sleep_select: assert property (@(posedge clk) disable iff (reset) // R12
		!cpuClockEnable |-> timer1Run == $past(timer1ExtClockSel) &&
			converterRun == $past(converterOscSel) &&
			watchdogRun == $past(watchdogRunsInSleep))
		else $error("clock source selection ignored in sleep");

	a_awake_running: assert property (@(posedge clk) disable iff (reset) // R10
		cpuClockEnable |-> watchdogRun && timer1Run && converterRun)
		else $error("peripheral stopped while the core runs");

	a_sense_osc: assert property (@(posedge clk) disable iff (reset) // R13
		senseOscRun)
		else $error("sense oscillator stopped");

	a_entry_pins: assert property (@(posedge clk) disable iff (reset) // R14
		entering |=> pinHold && state == irq_sleep_pkg::ASLEEP)
		else $error("sleep entry did not freeze the pins");

	a_pins_held: assert property (@(posedge clk) disable iff (reset) // R14
		state == irq_sleep_pkg::ASLEEP |-> pinHold)
		else $error("pins released while asleep");

	// first asleep cycle excluded: the address lands on the entry edge
	a_prefetch_hold: assert property (@(posedge clk) disable iff (reset) // R17
		state == irq_sleep_pkg::ASLEEP && $past(state) == irq_sleep_pkg::ASLEEP |->
			prefetchValid && $stable(prefetchAddr))
		else $error("prefetch lost during sleep");

	a_two_readback: assert property (@(posedge clk) disable iff (reset) // R5
		regRead && regAddr == irq_sleep_pkg::ADDR_REQUEST_TWO |=>
			(regReadData & ~irq_sleep_pkg::TWO_IMPL_MASK) == 8'h00)
		else $error("unused request bit read as one");

	a_flags_two_set: assert property (@(posedge clk) disable iff (reset) // R6
		eventsTwo[7] |=> requestTwo[7])
		else $error("oscillator fail event lost");

	a_vector_global: assert property (@(posedge clk) disable iff (reset) // R19
		vectorTake |-> $past(mainCtrl[irq_sleep_pkg::GLOBAL_EN_BIT]))
		else $error("vector taken with global enable clear");

	a_enabled_wakes: assert property (@(posedge clk) disable iff (reset) // R18
		mainCtrl[irq_sleep_pkg::PERIPH_EN_BIT] && |(enableTwo & requestTwo) |-> wakeRequest)
		else $error("enabled pending flag did not request wake");

	a_status_readonly: assert property (@(posedge clk) disable iff (reset) // R9
		regWrite && regAddr == irq_sleep_pkg::ADDR_STATUS && !sleepExec |=> $stable(statusReg))
		else $error("status changed by a register write");

	a_resume_pulse: assert property (@(posedge clk) disable iff (reset) // R16
		wakeResume |=> !wakeResume)
		else $error("resume held more than one cycle");

	a_state_onehot: assert property (@(posedge clk) disable iff (reset) // R15
		$onehot(state))
		else $error("power state not one-hot");
endmodule
`default_nettype wire

/* testbench/core_model.sv */
// core-side model: turns a request into one sleep instruction pulse
// assumes it shares clk with the controller
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        clk,
	input  wire logic        doSleep,
	input  wire logic [15:0] pcIn,
	output logic             sleepExec,
	output logic      [15:0] sleepPc
);
	initial begin
		sleepExec = 1'b0;
		sleepPc   = 16'h0000;
	end
	// pc only means something beside the pulse, so it churns otherwise
	always @(posedge clk) begin
		// the bench never relies on the instruction after sleep running first
		sleepExec <= doSleep;
		sleepPc   <= doSleep ? pcIn : ~sleepPc;
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// bench for the interrupt flag and sleep/wake controller
// assumes core_model issues sleep pulses; registers mirrored in mdl
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, reset, regWrite, regRead, doSleep;
	logic [3:0]  regAddr;
	logic [7:0]  regWriteData, regReadData, eventsOne, eventsTwo;
	logic [2:0]  coreEvents;
	logic        serialRxClear, serialTxClear, watchdogTimeout, watchdogRunsInSleep;
	logic        timer1ExtClockSel, converterOscSel, sleepExec;
	logic [15:0] sleepPc, pcIn, prefetchAddr, vectorAddr;
	logic        cpuClockEnable, watchdogClear, watchdogRun, timer1Run, converterRun;
	logic        senseOscRun, pinHold, prefetchValid, vectorTake, wakeResume;
	int          nMismatch = 0;
	int          nCompared = 0;
	int          mdl [8];

	core_model core_u (.clk, .doSleep, .pcIn, .sleepExec, .sleepPc);
	peripheral_irq_sleep_wake dut_u (.clk, .reset, .regAddr, .regWriteData, .regWrite,
		.regRead, .regReadData, .eventsOne, .eventsTwo, .serialRxClear, .serialTxClear,
		.coreEvents, .watchdogTimeout, .watchdogRunsInSleep, .timer1ExtClockSel,
		.converterOscSel, .sleepExec, .sleepPc, .cpuClockEnable, .watchdogClear,
		.watchdogRun, .timer1Run, .converterRun, .senseOscRun, .pinHold, .prefetchValid,
		.prefetchAddr, .vectorTake, .vectorAddr, .wakeResume);

	always #5 clk = ~clk;

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		nCompared++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chkB(input string nm, input logic exp, input logic got);
		nCompared++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR %s expected %b seen %b", nm, exp, got);
		end
	endtask

	// the trailing #1 keeps back-to-back calls from touching a strobe twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		case (a)
			4'h2, 4'h4: mdl[a] = d & irq_sleep_pkg::TWO_IMPL_MASK;
			4'h3: mdl[a] = (mdl[a] & 8'h30) | (d & irq_sleep_pkg::ONE_WRITE_MASK);
			4'h5, 4'h7: ;
			default: mdl[a] = d;
		endcase
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input string nm);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(nm, mdl[a][15:0], {8'h00, regReadData});
	endtask

	task automatic ev(input logic [7:0] e1, input logic [7:0] e2);
		eventsOne <= e1;
		eventsTwo <= e2;
		@(posedge clk);
		eventsOne <= 8'h00;
		eventsTwo <= 8'h00;
		#1 mdl[3] |= e1;
		mdl[4] |= e2 & irq_sleep_pkg::TWO_IMPL_MASK;
	endtask

	task automatic sleepRun(input logic global_irq_enable, input logic periph_irq_enable, input logic pend,
		input logic wd);
		logic [2:0]  lv;
		logic [15:0] pc;
		logic        nap;
		logic        seen;
		lv = 3'($urandom);
		pc = 16'($urandom);
		nap = !(periph_irq_enable && pend);
		seen = 1'b0;
		{watchdogRunsInSleep, timer1ExtClockSel, converterOscSel} <= lv;
		wr(irq_sleep_pkg::ADDR_MAIN_CTRL, {global_irq_enable, periph_irq_enable, 6'h00});
		if (pend)
			ev(8'h00, 8'h80);
		doSleep <= 1'b1;
		pcIn <= pc;
		@(posedge clk);
		doSleep <= 1'b0;
		@(posedge clk);
		#1 chkB("clock enable", !nap, cpuClockEnable);
		chkB("watchdog clear", nap, watchdogClear);
		chkB("pin hold", nap, pinHold);
		if (nap) begin
			chk("prefetch", pc + 16'h0001, prefetchAddr);
			chkB("prefetch valid", 1'b1, prefetchValid);
			chk("run", {12'h000, lv, 1'b1}, {12'h000, watchdogRun, timer1Run, converterRun, senseOscRun});
			mdl[5] = 8'h10;
		end
		rd(irq_sleep_pkg::ADDR_STATUS, "status");
		if (nap) begin
			if (wd)
				watchdogTimeout <= 1'b1;
			else
				ev(8'h00, 8'h80);
			for (int i = 0; i < 10 && wakeResume !== 1'b1; i++) begin
				@(posedge clk);
				#1 seen |= watchdogClear;
			end
			chkB("wake", 1'b1, wakeResume);
			chkB("wake watchdog clear", 1'b1, seen);
			chkB("vector take", global_irq_enable && !wd, vectorTake);
			if (global_irq_enable && !wd)
				chk("vector address", 16'h0004, vectorAddr);
			chkB("clock after wake", 1'b1, cpuClockEnable);
		end
		watchdogTimeout <= 1'b0;
		wr(irq_sleep_pkg::ADDR_REQUEST_TWO, 8'h00);
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h6fbe895f));
		{regWrite, regRead, doSleep, regAddr, regWriteData, eventsOne, eventsTwo} = '0;
		{coreEvents, serialRxClear, serialTxClear, watchdogTimeout, watchdogRunsInSleep} = '0;
		{timer1ExtClockSel, converterOscSel, pcIn} = '0;
		clk = 1'b0;
		reset = 1'b1;
		foreach (mdl[a]) mdl[a] = 0;
		mdl[5] = 8'h18;
		mdl[6] = 8'hff;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 8; a++)
			rd(4'(a), "reset value");
		for (int a = 0; a < 8; a++) begin
			wr(4'(a), 8'hf8);
			rd(4'(a), "write mask");
			wr(4'(a), 8'h00);
		end
		ev(8'($urandom), 8'($urandom));
		rd(irq_sleep_pkg::ADDR_REQUEST_ONE, "flags one");
		rd(irq_sleep_pkg::ADDR_REQUEST_TWO, "flags two");
		wr(irq_sleep_pkg::ADDR_REQUEST_ONE, 8'h00);
		rd(irq_sleep_pkg::ADDR_REQUEST_ONE, "read-only flags");
		serialRxClear <= 1'b1;
		serialTxClear <= 1'b1;
		@(posedge clk);
		serialRxClear <= 1'b0;
		serialTxClear <= 1'b0;
		mdl[3] = 0;
		rd(irq_sleep_pkg::ADDR_REQUEST_ONE, "serial clear");
		wr(irq_sleep_pkg::ADDR_REQUEST_TWO, 8'h00);
		wr(irq_sleep_pkg::ADDR_ENABLE_TWO, 8'h80);
		sleepRun(1'b0, 1'b1, 1'b0, 1'b0);
		sleepRun(1'b1, 1'b1, 1'b0, 1'b0);
		sleepRun(1'b0, 1'b0, 1'b1, 1'b1);
		sleepRun(1'b1, 1'b1, 1'b1, 1'b0);
		summarize();
	end

	initial begin
		repeat (3000) @(posedge clk);
		nMismatch++;
		summarize();
	end
endmodule
`default_nettype wire
